//--- pfas_pkg.sv
// package: constants and carriers of the timing flow analyzer signature block
package pfas_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int NE  = 3;
   localparam int NS  = 3;
   localparam int NF  = 8;
   localparam int NSB = 16;
   localparam int AW  = 12;
   localparam int OAM_ENG = 2;

   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [AW-1:0] OFS_CTRL  = 12'h000;
   localparam logic [AW-1:0] OFS_CMPEN = 12'h004;
   localparam logic [AW-1:0] OFS_STAT  = 12'h008;
   localparam logic [AW-1:0] OFS_ACHM  = 12'h00c;
   localparam logic [AW-1:0] OFS_ACHK  = 12'h010;
   localparam logic [AW-1:0] OFS_ACHO  = 12'h014;
   localparam logic [AW-1:0] OFS_STGEN = 12'h040;
   localparam logic [AW-1:0] OFS_FLOW  = 12'h080;
   localparam logic [AW-1:0] OFS_SEL   = 12'h100;

   // ****************************************
   // field positions
   // ****************************************
   localparam int CTRL_ENG   = 0;
   localparam int CTRL_STR   = 3;
   localparam int CTRL_ASRC  = 4;
   localparam int CTRL_USRC  = 6;
   localparam int FLOW_VAL   = 0;
   localparam int FLOW_CHM   = 1;
   localparam int FLOW_NPG   = 3;
   localparam int STAT_INPKT = 3;
   localparam int STAT_PEND  = 4;

   // ****************************************
   // reset values and signature codes
   // ****************************************
   localparam logic [NE-1:0]    RST_ENG   = 3'h0;
   localparam logic [NE*NS-1:0] RST_CMPEN = 9'h1ff;
   localparam logic [NF-1:0]    RST_STGEN = 8'h00;
   localparam logic [5:0] SEL_HDR_LAST = 6'h17;
   localparam logic [5:0] SEL_HDR6     = 6'h18;
   localparam logic [5:0] SEL_HDR4     = 6'h19;
   localparam logic [5:0] SEL_HDR0     = 6'h1a;
   localparam logic [5:0] SEL_ADR0     = 6'h1c;
   localparam logic [5:0] SEL_ADR7     = 6'h23;
   localparam logic [5:0] SEL_HDR_BASE = 6'h1f;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic sof;
      logic eof;
      logic egress;
      logic chan_b;
      logic eth_found;
      logic mpls_done;
   } pfas_frm_t;

   typedef struct packed {
      logic [NE-1:0][NS-1:0][NF-1:0] hit;
      logic [31:0][7:0]              hdr;
      logic [3:0][1:0][63:0]         addr;
   } pfas_cmp_t;

   typedef struct packed {
      logic                   sig_valid;
      logic [NSB-1:0][7:0]    sig;
      logic [NE-1:0]          eng_match;
      logic                   ts_all;
      logic [NE-1:0][NF-1:0]  flow_active;
   } pfas_res_t;

   typedef struct packed {
      logic        start;
      logic [31:0] match;
      logic [31:0] mask;
      logic [7:0]  offset;
   } pfas_ach_t;

endpackage

//--- pfas_top.sv
// module: reconfiguration, flow gating and frame signature builder of the timing flow analyzer
//
// Notes on behaviour
// - disabled engine reconfigures freely, others keep running
// - per-stage, per-flow enable bits
// - comparators disableable; no ethernet header, no match
// - first ethernet comparator off stamps every frame
// - enable changes applied only between packets
// - strict mode: stage disable kills whole flow
// - egress-only signature of up to 16 bytes
// - select 0-23 takes header byte 31-select
// - selects 24,25,26 take header bytes 6,4,0
// - selects 28-35 take selected address byte
// - sixteen 6-bit selectors, byte 0 least significant
// - 2-bit address source picks comparator block
// - per block source or destination address choice
// - all engines give signatures; third engine limited
// - third engine part A or B picks block
// - part B with second ethernet gives zeros
// - shared config, per-flow channel mask
// - channel header compare starts after label compare
// - first ethernet reports protocol set A/B bits
// - next block only matches sets matched before; flows from PARTB_FIRST up pass the later blocks unchecked
// - per-flow 2-bit next-protocol group mask
// - per-flow valid enable gates all its fields; an invalid flow's group mask still feeds the protocol set
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

module pfas_top
   import pfas_pkg::*;
#(
   parameter int PARTB_FIRST = 4
)
(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_b_i,
   // apb slave
   input  wire logic                  psel_i,
   input  wire logic                  penable_i,
   input  wire logic                  pwrite_i,
   input  wire logic [pfas_pkg::AW-1:0] paddr_i,
   input  wire logic [31:0]           pwdata_i,
   output logic      [31:0]           prdata_o,
   output logic                       pready_o,
   output logic                       pslverr_o,
   // frame data path and comparators
   input  wire pfas_pkg::pfas_frm_t   frm_i,
   input  wire pfas_pkg::pfas_cmp_t   cmp_i,
   // results
   output pfas_pkg::pfas_res_t        res_o,
   output pfas_pkg::pfas_ach_t        ach_o
);
   import pfas_pkg::*;

   // ****************************************
   // registers
   // ****************************************
   logic [NE-1:0]             eng_req_q;
   logic [NE-1:0]             eng_q;
   logic [NE*NS-1:0]          cmp_req_q;
   logic [NE*NS-1:0]          cmp_q;
   logic [NE*NS-1:0][NF-1:0]  stg_req_q;
   logic [NE*NS-1:0][NF-1:0]  stg_q;
   logic [NF-1:0]             fval_req_q;
   logic [NF-1:0]             fval_q;
   logic [NF-1:0][1:0]        chm_q;
   logic [NF-1:0][1:0]        npg_q;
   logic [NSB-1:0][5:0]       sel_q;
   logic                      strict_q;
   logic [1:0]                asrc_q;
   logic [3:0]                usrc_q;
   logic [31:0]               achm_q;
   logic [31:0]               achk_q;
   logic [7:0]                acho_q;
   logic                      in_pkt_q;
   logic                      pready_q;
   logic                      pslverr_q;
   logic [31:0]               prdata_q;
   pfas_res_t                 res_q;
   logic                      ach_start_q;

   logic                      access;
   logic                      wr_en;
   logic                      boundary;
   logic                      pending;
   logic                      hit_reg;
   logic [31:0]               rd_d;

   // ****************************************
   // apb access
   // ****************************************
   assign access = psel_i & penable_i & ~pready_q;
   assign wr_en  = psel_i & penable_i & pready_q & pwrite_i;

   always_comb
   begin
      rd_d    = 32'h0000_0000;
      hit_reg = 1'b1;
      if (paddr_i == OFS_CTRL)
         rd_d = {22'h0, usrc_q, asrc_q, strict_q, eng_req_q};
      else if (paddr_i == OFS_CMPEN)
         rd_d = {23'h0, cmp_req_q};
      else if (paddr_i == OFS_STAT)
         rd_d = {27'h0, pending, in_pkt_q, eng_q};
      else if (paddr_i == OFS_ACHM)
         rd_d = achm_q;
      else if (paddr_i == OFS_ACHK)
         rd_d = achk_q;
      else if (paddr_i == OFS_ACHO)
         rd_d = {24'h0, acho_q};
      else
      begin
         hit_reg = 1'b0;
         for (int k = 0; k < NE*NS; k++)
         begin
            if (paddr_i == OFS_STGEN + AW'(4*k))
            begin
               rd_d    = {24'h0, stg_req_q[k]};
               hit_reg = 1'b1;
            end
         end
         for (int f = 0; f < NF; f++)
         begin
            if (paddr_i == OFS_FLOW + AW'(4*f))
            begin
               rd_d    = {27'h0, npg_q[f], chm_q[f], fval_req_q[f]};
               hit_reg = 1'b1;
            end
         end
         for (int i = 0; i < NSB; i++)
         begin
            if (paddr_i == OFS_SEL + AW'(4*i))
            begin
               rd_d    = {26'h0, sel_q[i]};
               hit_reg = 1'b1;
            end
         end
      end
   end

   // one wait cycle, then registered answer
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end
      else
      begin
         pready_q  <= access;
         pslverr_q <= access & ~hit_reg;
         if (access & ~pwrite_i)
            prdata_q <= rd_d;
      end
   end

   assign pready_o  = pready_q;
   assign pslverr_o = pslverr_q;
   assign prdata_o  = prdata_q;

   // ****************************************
   // software written registers
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         eng_req_q <= RST_ENG;
         cmp_req_q <= RST_CMPEN;
         strict_q  <= 1'b0;
         asrc_q    <= 2'h0;
         usrc_q    <= 4'h0;
         achm_q    <= 32'h0000_0000;
         achk_q    <= 32'h0000_0000;
         acho_q    <= 8'h00;
      end
      else if (wr_en)
      begin
         if (paddr_i == OFS_CTRL)
         begin
            eng_req_q <= pwdata_i[CTRL_ENG +: NE];
            strict_q  <= pwdata_i[CTRL_STR];
            asrc_q    <= pwdata_i[CTRL_ASRC +: 2];
            usrc_q    <= pwdata_i[CTRL_USRC +: 4];
         end
         if (paddr_i == OFS_CMPEN)
            cmp_req_q <= pwdata_i[NE*NS-1:0];
         if (paddr_i == OFS_ACHM)
            achm_q <= pwdata_i;
         if (paddr_i == OFS_ACHK)
            achk_q <= pwdata_i;
         if (paddr_i == OFS_ACHO)
            acho_q <= pwdata_i[7:0];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NE*NS; g++)
      begin : g_stg
         always_ff @(posedge clk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
               stg_req_q[g] <= RST_STGEN;
            else if (wr_en && paddr_i == OFS_STGEN + AW'(4*g))
               stg_req_q[g] <= pwdata_i[NF-1:0];
         end
      end
      for (g = 0; g < NF; g++)
      begin : g_flow
         always_ff @(posedge clk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
            begin
               fval_req_q[g] <= 1'b0;
               chm_q[g]      <= 2'h0;
               npg_q[g]      <= 2'h0;
            end
            else if (wr_en && paddr_i == OFS_FLOW + AW'(4*g))
            begin
               fval_req_q[g] <= pwdata_i[FLOW_VAL];
               chm_q[g]      <= pwdata_i[FLOW_CHM +: 2];
               npg_q[g]      <= pwdata_i[FLOW_NPG +: 2];
            end
         end
      end
      for (g = 0; g < NSB; g++)
      begin : g_sel
         always_ff @(posedge clk_i or negedge rst_b_i)
         begin
            if (!rst_b_i)
               sel_q[g] <= 6'h00;
            else if (wr_en && paddr_i == OFS_SEL + AW'(4*g))
               sel_q[g] <= pwdata_i[5:0];
         end
      end
   endgenerate

   // ****************************************
   // packet boundary and applied enables
   // ****************************************
   assign boundary = (~in_pkt_q & ~frm_i.sof) | frm_i.eof;
   assign pending  = (eng_req_q != eng_q) | (cmp_req_q != cmp_q)
                   | (stg_req_q != stg_q) | (fval_req_q != fval_q);

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         in_pkt_q <= 1'b0;
      else if (frm_i.sof)
         in_pkt_q <= 1'b1;
      else if (frm_i.eof)
         in_pkt_q <= 1'b0;
   end

   // requests written mid-packet wait here
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         eng_q  <= RST_ENG;
         cmp_q  <= RST_CMPEN;
         stg_q  <= {NE*NS{RST_STGEN}};
         fval_q <= '0;
      end
      else if (boundary)
      begin
         eng_q  <= eng_req_q;
         cmp_q  <= cmp_req_q;
         stg_q  <= stg_req_q;
         fval_q <= fval_req_q;
      end
   end

   // ****************************************
   // flow matching
   // ****************************************
   logic [NE-1:0][NF-1:0] fmatch;
   logic [NE-1:0][NF-1:0] factive;
   logic [NS-1:0][1:0]    pset;
   logic                  partb_hit;
   logic                  parta_hit;

   always_comb
   begin
      logic [NF-1:0] pass;
      logic [NF-1:0] allow;
      logic [NF-1:0] sh;
      logic          cen;
      pass    = '0;
      allow   = '0;
      sh      = '0;
      cen     = 1'b0;
      pset    = '0;
      fmatch  = '0;
      factive = '0;
      for (int e = 0; e < NE; e++)
      begin
         pass = {NF{eng_q[e]}};
         for (int f = 0; f < NF; f++)
         begin
            pass[f] = pass[f] & fval_q[f] & chm_q[f][frm_i.chan_b];
            factive[e][f] = eng_q[e] & fval_q[f];
            if (strict_q)
               for (int s = 0; s < NS; s++)
                  factive[e][f] = factive[e][f] & stg_q[e*NS+s][f];
         end
         for (int s = 0; s < NS; s++)
         begin
            cen   = cmp_q[e*NS+s];
            sh    = cmp_i.hit[e][s] & stg_q[e*NS+s];
            allow = {NF{1'b1}};
            if (e == OAM_ENG && s > 0)
               for (int f = 0; f < NF; f++)
                  allow[f] = |(npg_q[f] & pset[s-1]);
            for (int f = 0; f < NF; f++)
            begin
               if (e == OAM_ENG && s > 0 && f >= PARTB_FIRST)
                  sh[f] = 1'b1;
               else if (!cen)
                  sh[f] = 1'b1;
               else
                  sh[f] = sh[f] & allow[f];
            end
            if (s == 0 && cen && !frm_i.eth_found)
               sh = '0;
            if (e == OAM_ENG)
               for (int f = 0; f < NF; f++)
                  if (sh[f] && cen)
                     pset[s] = pset[s] | npg_q[f];
            pass = pass & sh;
         end
         fmatch[e]  = pass & factive[e];
      end
   end

   always_comb
   begin
      partb_hit = 1'b0;
      parta_hit = 1'b0;
      for (int f = 0; f < NF; f++)
      begin
         if (f >= PARTB_FIRST)
            partb_hit = partb_hit | fmatch[OAM_ENG][f];
         else
            parta_hit = parta_hit | fmatch[OAM_ENG][f];
      end
   end

   // ****************************************
   // signature builder
   // ****************************************
   logic [63:0]         sel_addr;
   logic [NSB-1:0][7:0] sig_d;
   logic                ts_all;
   logic                eng_ab_hit;

   function automatic logic [7:0] sig_byte(input logic [5:0] s,
                                           input logic [31:0][7:0] hdr,
                                           input logic [63:0] adr);
      logic [5:0] idx;
      idx = 6'h00;
      if (s <= SEL_HDR_LAST)
      begin
         idx = SEL_HDR_BASE - s;
         return hdr[idx[4:0]];
      end
      else if (s == SEL_HDR6)
         return hdr[6];
      else if (s == SEL_HDR4)
         return hdr[4];
      else if (s == SEL_HDR0)
         return hdr[0];
      else if (s >= SEL_ADR0 && s <= SEL_ADR7)
      begin
         idx = s - SEL_ADR0;
         return adr[idx[2:0]*8 +: 8];
      end
      return 8'h00;
   endfunction

   assign eng_ab_hit = |fmatch[0] | |fmatch[1];

   always_comb
   begin
      sel_addr = cmp_i.addr[asrc_q][usrc_q[asrc_q]];
      if (!eng_ab_hit)
      begin
         if (asrc_q == 2'h0)
            sel_addr = cmp_i.addr[0][usrc_q[0]];
         else if (asrc_q == 2'h1 && parta_hit)
            sel_addr = cmp_i.addr[1][usrc_q[1]];
         else
            sel_addr = 64'h0;
      end
   end

   generate
      for (g = 0; g < NSB; g++)
      begin : g_sig
         assign sig_d[g] = sig_byte(sel_q[g], cmp_i.hdr, sel_addr);
      end
   endgenerate

   always_comb
   begin
      ts_all = 1'b0;
      for (int e = 0; e < NE; e++)
         ts_all = ts_all | (eng_q[e] & ~cmp_q[e*NS]);
   end

   // ****************************************
   // result and channel header outputs
   // ****************************************
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         res_q <= '0;
      else
      begin
         res_q.ts_all      <= ts_all;
         res_q.flow_active <= factive;
         res_q.sig_valid   <= 1'b0;
         if (frm_i.eof)
         begin
            for (int e = 0; e < NE; e++)
               res_q.eng_match[e] <= |fmatch[e] | (eng_q[e] & ts_all);
            if (frm_i.egress && (|fmatch || ts_all))
            begin
               res_q.sig_valid <= 1'b1;
               res_q.sig       <= sig_d;
            end
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         ach_start_q <= 1'b0;
      else
         ach_start_q <= frm_i.mpls_done & eng_q[OAM_ENG];
   end

   assign res_o        = res_q;
   assign ach_o.start  = ach_start_q;
   assign ach_o.match  = achm_q;
   assign ach_o.mask   = achk_q;
   assign ach_o.offset = acho_q;

endmodule

`default_nettype wire

//--- pfas_top_asserts.sv
// checker: port-level assertions of the signature block
`timescale 1ns/1ps
`default_nettype none

module pfas_chk
   import pfas_pkg::*;
#(
   parameter int PARTB_FIRST = 4
)
(
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_b_i,
   // apb
   input  wire logic                    psel_i,
   input  wire logic                    penable_i,
   input  wire logic                    pwrite_i,
   input  wire logic [pfas_pkg::AW-1:0] paddr_i,
   input  wire logic [31:0]             pwdata_i,
   input  wire logic [31:0]             prdata_o,
   input  wire logic                    pready_o,
   input  wire logic                    pslverr_o,
   // frame side and results
   input  wire pfas_pkg::pfas_frm_t     frm_i,
   input  wire pfas_pkg::pfas_cmp_t     cmp_i,
   input  wire pfas_pkg::pfas_res_t     res_o,
   input  wire pfas_pkg::pfas_ach_t     ach_o
);
   import pfas_pkg::*;

   // ****************************************
   // packet boundary tracking
   // ****************************************
   logic in_pkt_q;
   logic bnd;

   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         in_pkt_q <= 1'b0;
      else if (frm_i.eof)
         in_pkt_q <= 1'b0;
      else if (frm_i.sof)
         in_pkt_q <= 1'b1;
   end

   assign bnd = (!in_pkt_q && !frm_i.sof) || frm_i.eof;

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);

   AST_RDY: assert property (psel_i && penable_i && !pready_o |=> pready_o)
      else $error("apb access not answered");
   AST_SIG_EGR: assert property (res_o.sig_valid |-> $past(frm_i.eof && frm_i.egress))
      else $error("signature without egress frame end");
   AST_SIG_INGR: assert property (frm_i.eof && !frm_i.egress |=> !res_o.sig_valid)
      else $error("signature for ingress frame");
   AST_SIG_HOLD: assert property (!$past(frm_i.eof) |-> $stable(res_o.sig))
      else $error("signature changed off frame end");
   AST_ENG_HOLD: assert property (!$past(frm_i.eof) |-> $stable(res_o.eng_match))
      else $error("engine match changed off frame end");
   AST_ACH: assert property (ach_o.start |-> $past(frm_i.mpls_done))
      else $error("channel header start without label end");
   AST_TS_BND: assert property ($changed(res_o.ts_all) |-> $past(bnd) || $past(bnd, 2))
      else $error("stamp-all changed inside packet");
   AST_FLOW_BND: assert property ($changed(res_o.flow_active) |-> $past(bnd) || $past(bnd, 2))
      else $error("flow enables changed inside packet");

   cover property (res_o.sig_valid);
   cover property (ach_o.start);
   cover property (pready_o && pslverr_o);
endmodule

bind pfas_top pfas_chk #(.PARTB_FIRST(PARTB_FIRST)) u_chk (
   .clk_i     (clk_i),
   .rst_b_i   (rst_b_i),
   .psel_i    (psel_i),
   .penable_i (penable_i),
   .pwrite_i  (pwrite_i),
   .paddr_i   (paddr_i),
   .pwdata_i  (pwdata_i),
   .prdata_o  (prdata_o),
   .pready_o  (pready_o),
   .pslverr_o (pslverr_o),
   .frm_i     (frm_i),
   .cmp_i     (cmp_i),
   .res_o     (res_o),
   .ach_o     (ach_o)
);

`default_nettype wire

//--- pfas_frame_src.sv
// partner: frame data path and comparator results feeding the block
`timescale 1ns/1ps
`default_nettype none

module pfas_frame_src
   import pfas_pkg::*;
(
   // clock
   input  wire logic               clk_i,
   // frame side
   output var pfas_pkg::pfas_frm_t frm_o,
   output var pfas_pkg::pfas_cmp_t cmp_o
);
   import pfas_pkg::*;

   int n = 0;

   initial
   begin
      frm_o = '0;
      cmp_o = '0;
   end

   // header and addresses valid from frame start
   task automatic open_frame(input logic eg);
      @(posedge clk_i);
      frm_o.sof <= 1'b1;
      frm_o.egress <= eg;
      frm_o.eth_found <= 1'b1;
      for (int i = 0; i < 32; i++)
         cmp_o.hdr[i] <= 8'(i * 7 + n);
      for (int b = 0; b < 64; b++)
         cmp_o.addr[b / 16][(b / 8) % 2][(b % 8) * 8 +: 8] <= 8'(8'h80 + b * 5 + n);
      @(posedge clk_i);
      frm_o.sof <= 1'b0;
   endtask

   // hits stable at eof, data lines scrambled after
   task automatic close_frame(input logic [NE-1:0][NS-1:0][NF-1:0] h);
      @(posedge clk_i);
      cmp_o.hit <= h;
      frm_o.mpls_done <= 1'b1;
      @(posedge clk_i);
      frm_o.mpls_done <= 1'b0;
      frm_o.eof <= 1'b1;
      @(posedge clk_i);
      frm_o.eof <= 1'b0;
      frm_o.eth_found <= 1'b0;
      cmp_o.hit <= '0;
      cmp_o.hdr <= ~cmp_o.hdr;
      cmp_o.addr <= ~cmp_o.addr;
      n++;
   endtask
endmodule

`default_nettype wire

//--- pfas_top_tb.sv
// testbench: register access and frame signature scenarios
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
   begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s exp %h got %h", nm, e, g); end end

module pfas_top_tb;
   import pfas_pkg::*;

   // ****************************************
   // signals
   // ****************************************
   logic                 clk_i   = 1'b0;
   logic                 rst_b_i = 1'b0;
   logic                 psel    = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite  = 1'b0;
   logic [AW-1:0]        paddr   = '0;
   logic [31:0]          pwdata  = '0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   pfas_frm_t            frm;
   pfas_cmp_t            cmp;
   pfas_res_t            res;
   pfas_ach_t            ach;
   logic [31:0]          rdat;
   logic                 rerr;
   logic                 ach_seen = 1'b0;
   logic [NSB-1:0][7:0]  exp_sig;
   logic [NE-1:0][NS-1:0][NF-1:0] h0;
   logic [NE-1:0][NS-1:0][NF-1:0] h2;
   int                   num_errors = 0;
   int                   cmp_count  = 0;
   logic [5:0]           sel_tab [16] = '{6'h00, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, 6'h1d,
                                          6'h1e, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h23, 6'h05, 6'h28};

   always #20 clk_i = ~clk_i;

   // remembers any channel header start pulse
   always @(posedge clk_i)
      if (ach.start === 1'b1)
         ach_seen <= 1'b1;

   pfas_top #(.PARTB_FIRST(4)) DUT (
      .clk_i     (clk_i),
      .rst_b_i   (rst_b_i),
      .psel_i    (psel),
      .penable_i (penable),
      .pwrite_i  (pwrite),
      .paddr_i   (paddr),
      .pwdata_i  (pwdata),
      .prdata_o  (prdata),
      .pready_o  (pready),
      .pslverr_o (pslverr),
      .frm_i     (frm),
      .cmp_i     (cmp),
      .res_o     (res),
      .ach_o     (ach)
   );

   pfas_frame_src u_src (
      .clk_i (clk_i),
      .frm_o (frm),
      .cmp_o (cmp)
   );

   // ****************************************
   // tasks
   // ****************************************
   task automatic results();
      if (num_errors == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
         num_errors++;
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [AW-1:0] a, input logic [31:0] e, input logic er);
      apb(1'b0, a, 32'h0);
      `CHK("rdata", e, rdat)
      `CHK("slverr", er, rerr)
   endtask

   function automatic logic [7:0] map_byte(input logic [5:0] s, input logic [31:0][7:0] h,
                                           input logic [63:0] a);
      int k;
      k = int'(s);
      if (k <= 23)
         return h[31 - k];
      if (k == 24)
         return h[6];
      if (k == 25)
         return h[4];
      if (k == 26)
         return h[0];
      if (k >= 28 && k <= 35)
         return a[(k - 28) * 8 +: 8];
      return 8'h00;
   endfunction

   // blk below zero: address bytes expected as zeros
   task automatic frame(input logic eg, input logic [NE-1:0][NS-1:0][NF-1:0] h, input int blk,
                        input int sd, input logic mid);
      logic [63:0] a;
      u_src.open_frame(eg);
      a = (blk < 0) ? 64'h0 : cmp.addr[blk][sd];
      for (int i = 0; i < NSB; i++)
         exp_sig[i] = map_byte(sel_tab[i], cmp.hdr, a);
      if (mid)
      begin
         wr(OFS_CTRL, 32'h3f0);
         rd(OFS_STAT, 32'h19, 1'b0);
      end
      u_src.close_frame(h);
      @(negedge clk_i);
   endtask

   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      #800000;
      num_errors++;
      results();
   end

   initial
   begin
      h0 = '0;
      h2 = '0;
      for (int s = 0; s < NS; s++)
      begin
         h0[0][s][0] = 1'b1;
         h2[2][s][4] = 1'b1;
      end
      repeat (10) @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd(OFS_CTRL, 32'h0, 1'b0);
      rd(OFS_CMPEN, 32'h1ff, 1'b0);
      rd(OFS_STGEN, 32'h0, 1'b0);
      rd(OFS_FLOW, 32'h0, 1'b0);
      rd(12'hffc, 32'h0, 1'b1);
      wr(OFS_STAT, 32'hffffffff);
      rd(OFS_STAT, 32'h0, 1'b0);
      for (int i = 0; i < NSB; i++)
         wr(OFS_SEL + 12'(4 * i), 32'(sel_tab[i]));
      for (int s = 0; s < NS; s++)
         wr(OFS_STGEN + 12'(4 * s), 32'h01);
      wr(OFS_FLOW, 32'h1b);
      for (int a = 0; a < 4; a++)
      begin
         wr(OFS_CTRL, (32'(a) << 4) | ((a % 2) ? 32'h3c0 : 32'h0));
         wr(OFS_CTRL, (32'(a) << 4) | ((a % 2) ? 32'h3c1 : 32'h1));
         frame(1'b1, h0, a, a % 2, 1'b0);
         `CHK("sig_valid", 1'b1, res.sig_valid)
         `CHK("sig", exp_sig, res.sig)
         `CHK("eng_match", 3'b001, res.eng_match)
      end
      frame(1'b0, h0, 0, 0, 1'b0);
      `CHK("sig_valid", 1'b0, res.sig_valid)
      frame(1'b1, h0, 3, 1, 1'b1);
      `CHK("sig_valid", 1'b1, res.sig_valid)
      `CHK("sig", exp_sig, res.sig)
      frame(1'b1, h0, 3, 1, 1'b0);
      `CHK("sig_valid", 1'b0, res.sig_valid)
      `CHK("eng_match", 3'b000, res.eng_match)
      `CHK("ach_start", 1'b0, ach_seen)
      wr(OFS_ACHM, 32'hc0de_0001);
      wr(OFS_ACHK, 32'hffff_ff00);
      wr(OFS_ACHO, 32'h0000_0024);
      @(negedge clk_i);
      `CHK("ach_match", 32'hc0de_0001, ach.match)
      `CHK("ach_mask", 32'hffff_ff00, ach.mask)
      `CHK("ach_offset", 8'h24, ach.offset)
      for (int s = 0; s < NS; s++)
         wr(OFS_STGEN + 12'(4 * (6 + s)), 32'h10);
      wr(OFS_FLOW + 12'h010, 32'h1b);
      wr(OFS_CTRL, 32'h14);
      frame(1'b1, h2, -1, 0, 1'b0);
      `CHK("sig", exp_sig, res.sig)
      `CHK("ach_start", 1'b1, ach_seen)
      `CHK("eng_match", 3'b100, res.eng_match)
      wr(OFS_CTRL, 32'h01);
      wr(OFS_CMPEN, 32'h1fe);
      frame(1'b1, '0, 0, 0, 1'b0);
      `CHK("ts_all", 1'b1, res.ts_all)
      `CHK("sig_valid", 1'b1, res.sig_valid)
      `CHK("sig", exp_sig, res.sig)
      `CHK("flow_active", 24'h000011, res.flow_active)
      wr(OFS_STGEN + 12'h004, 32'h00);
      wr(OFS_CTRL, 32'h09);
      repeat (2) @(negedge clk_i);
      `CHK("flow_active", 24'h000000, res.flow_active)
      results();
   end
endmodule

`default_nettype wire
